/* hdl/pdr_cnt_if.sv */
// link between the register bank and the prbs error counter
`timescale 1ns/1ns
interface pdr_cnt_if;
    logic       err;
    logic       mode;
    logic       clr;
    logic [7:0] count;
    logic       sat;

    modport cnt (input err, input mode, input clr,
                 output count, output sat);
    modport ctl (output err, output mode, output clr,
                 input count, input sat);
endinterface

/* hdl/pdr_errcnt.sv */
// running count of errored bytes seen by the prbs checker
`timescale 1ns/1ns
`include "pdr_params.svh"
module pdr_errcnt
    import pdr_pkg::*;
(
    input  wire logic CLK,
    input  wire logic NRST,
    pdr_cnt_if.cnt    cif
);

    pdr_cnt_s s_q;
    pdr_cnt_s s_d;

    // wrap only in mode 1; mode 0 holds at the top
    always_comb begin
        s_d = s_q;
        s_d.sat = 1'b0;
        if (cif.clr) begin
            s_d.count = 8'h00;
        end else if (cif.err) begin
            if (s_q.count == `PDR_ERR_MAX && !cif.mode) begin
                s_d.sat = 1'b1;
            end else begin
                s_d.count = s_q.count + 8'h01;
            end
        end
    end

    // state register
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign cif.count = s_q.count;
    assign cif.sat   = s_q.sat;

endmodule

/* hdl/pdr_params.svh */
// register offsets, field positions, reset values of the phy regs
`ifndef PDR_PARAMS_SVH
`define PDR_PARAMS_SVH

`define PDR_AW        6
`define PDR_A_TENB    6'h1A
`define PDR_A_ERRGAP  6'h1B
`define PDR_A_PKTLEN  6'h1C
`define PDR_A_CDIAG   6'h1E
`define PDR_A_RSTCTL  6'h1F
`define PDR_A_INTST   6'h20
`define PDR_A_INTMK   6'h21

`define PDR_SQ_HI     12
`define PDR_SQ_LO     9
`define PDR_NLP_BIT   7
`define PDR_POL_BIT   4
`define PDR_JAB_BIT   0
`define PDR_ERR_HI    15
`define PDR_ERR_LO    8
`define PDR_LATCH_BIT 15
`define PDR_IPG_HI    7
`define PDR_LEN_HI    10
`define PDR_CDS_BIT   15
`define PDR_CDD_BIT   1
`define PDR_CDF_BIT   0
`define PDR_SWR_BIT   15
`define PDR_DGR_BIT   14

`define PDR_SQ_RST    4'h0
`define PDR_IPG_RST   8'h7D
`define PDR_LEN_RST   11'h5EE
`define PDR_ERR_MAX   8'hFF

`define PDR_INT_POL   0
`define PDR_INT_CDD   1
`define PDR_INT_CDF   2
`define PDR_INT_SAT   3
`define PDR_NINT      4

`endif

/* hdl/pdr_pkg.sv */
// types shared by the phy diagnostic register bank
package pdr_pkg;

    // cable measurement handshake
    typedef enum logic [1:0] {
        PDR_CD_IDLE = 2'b00,
        PDR_CD_RUN  = 2'b01
    } pdr_cd_e;

    typedef struct packed {
        logic [3:0]  squelch;
        logic        nlp_dis;
        logic        pol;
        logic        jab_dis;
        logic        jab_en;
        logic [7:0]  err_lat;
        logic [7:0]  ipg;
        logic [10:0] len;
        pdr_cd_e     cd;
        logic        cd_fail;
        logic        swrst;
        logic        digrst;
        logic [3:0]  int_st;
        logic [3:0]  int_mk;
        logic        irq;
        logic [15:0] rdata;
    } pdr_regs_s;

    typedef struct packed {
        logic [7:0] count;
        logic       sat;
    } pdr_cnt_s;

endpackage

/* hdl/pdr_regs.sv */
// control and status registers: 10 Mb/s, self-test, cable, reset
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ns
`include "pdr_params.svh"

// Overview of operation
// - four-bit squelch code sets receiver threshold
// - suppression bit set stops link pulses
// - polarity flag shows inverted 10 Mb/s pair
// - polarity flag mirrored to general status
// - own register read clears both copies
// - jabber bit disables jabber, 10 Mb/s only
// - eight-bit errored byte count, bits 15:8
// - bit 15 write latches count, clears counter
// - mode zero saturates counter at FF
// - gap between generated packets, default 7D
// - generated packet length, default 5EE
// - start bit begins cable measurement
// - start self-clears when done rises
// - done flag, reset value one
// - fail flag shows failed measurement
// - software reset acts like reset pin
// - digital restart keeps register contents
module pdr_regs
    import pdr_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        NRST,
    input  wire logic [5:0]  ADDR,
    input  wire logic [15:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [15:0] RDATA,
    input  wire logic        POL_DET,
    input  wire logic        PRBS_ERR,
    input  wire logic        ERR_MODE,
    input  wire logic        SPEED10,
    input  wire logic        CD_DONE,
    input  wire logic        CD_FAIL,
    output logic      [3:0]  SQUELCH,
    output logic             NLP_OFF,
    output logic             POL_MIRROR,
    output logic             JABBER_EN,
    output logic      [7:0]  IPG_LEN,
    output logic      [10:0] PKT_LEN,
    output logic             CD_START,
    output logic             SOFT_RST,
    output logic             DIG_RST,
    output logic             IRQ
);

    pdr_regs_s s_q;
    pdr_regs_s s_d;
    pdr_cnt_if cif ();

    logic [3:0] ev;

    // reset image shared by the pin and the soft reset
    function automatic pdr_regs_s rst_val();
        pdr_regs_s r;
        r = '0;
        r.squelch = `PDR_SQ_RST;
        r.ipg     = `PDR_IPG_RST;
        r.len     = `PDR_LEN_RST;
        r.cd      = PDR_CD_IDLE;
        return r;
    endfunction

    // address hit on a write
    function automatic logic wr_hit(logic [5:0] a);
        return WR && (ADDR == a);
    endfunction

    // latch write or either reset clears; inline compare wakes on WR
    assign cif.err  = PRBS_ERR;
    assign cif.mode = ERR_MODE;
    assign cif.clr  = s_q.swrst || s_q.digrst
        || (WR && (ADDR == `PDR_A_ERRGAP) && WDATA[`PDR_LATCH_BIT]);

    pdr_errcnt u_cnt (
        .CLK  (CLK),
        .NRST (NRST),
        .cif  (cif)
    );

    // events that raise sticky interrupt bits
    always_comb begin
        ev = 4'h0;
        ev[`PDR_INT_POL] = POL_DET;
        ev[`PDR_INT_CDD] = CD_DONE && (s_q.cd == PDR_CD_RUN);
        ev[`PDR_INT_CDF] = CD_DONE && CD_FAIL
            && (s_q.cd == PDR_CD_RUN);
        ev[`PDR_INT_SAT] = cif.sat;
    end

    // next state of the whole bank
    always_comb begin
        s_d = s_q;
        s_d.swrst  = 1'b0;
        s_d.digrst = 1'b0;
        s_d.rdata  = 16'h0000;

        // control fields, reserved bits dropped
        if (wr_hit(`PDR_A_TENB)) begin
            s_d.squelch = WDATA[`PDR_SQ_HI:`PDR_SQ_LO];
            s_d.nlp_dis = WDATA[`PDR_NLP_BIT];
            s_d.jab_dis = WDATA[`PDR_JAB_BIT];
        end
        if (wr_hit(`PDR_A_ERRGAP)) begin
            s_d.ipg = WDATA[`PDR_IPG_HI:0];
            if (WDATA[`PDR_LATCH_BIT]) begin
                s_d.err_lat = cif.count;
            end
        end
        if (wr_hit(`PDR_A_PKTLEN)) begin
            s_d.len = WDATA[`PDR_LEN_HI:0];
        end
        if (wr_hit(`PDR_A_RSTCTL)) begin
            s_d.swrst  = WDATA[`PDR_SWR_BIT];
            s_d.digrst = WDATA[`PDR_DGR_BIT];
        end
        if (wr_hit(`PDR_A_INTMK)) begin
            s_d.int_mk = WDATA[`PDR_NINT-1:0];
        end

        // cable measurement handshake
        case (s_q.cd)
            PDR_CD_IDLE: begin
                if (wr_hit(`PDR_A_CDIAG)
                    && WDATA[`PDR_CDS_BIT]) begin
                    s_d.cd      = PDR_CD_RUN;
                    s_d.cd_fail = 1'b0;
                end
            end
            PDR_CD_RUN: begin
                // finishing wins over a late abort write
                if (CD_DONE) begin
                    s_d.cd      = PDR_CD_IDLE;
                    s_d.cd_fail = CD_FAIL;
                end else if (wr_hit(`PDR_A_CDIAG)
                    && !WDATA[`PDR_CDS_BIT]) begin
                    s_d.cd = PDR_CD_IDLE;
                end
            end
            default: begin
                s_d.cd = PDR_CD_IDLE;
            end
        endcase

        // read of own register clears, new detection wins
        if (RD && ADDR == `PDR_A_TENB) begin
            s_d.pol = 1'b0;
        end
        if (POL_DET) begin
            s_d.pol = 1'b1;
        end

        // sticky status: write one to clear, set wins
        if (wr_hit(`PDR_A_INTST)) begin
            s_d.int_st = s_q.int_st & ~WDATA[`PDR_NINT-1:0];
        end
        s_d.int_st = s_d.int_st | ev;

        // read data, zero on reserved bits and holes
        if (RD) begin
            case (ADDR)
                `PDR_A_TENB: begin
                    s_d.rdata[`PDR_SQ_HI:`PDR_SQ_LO] = s_q.squelch;
                    s_d.rdata[`PDR_NLP_BIT] = s_q.nlp_dis;
                    s_d.rdata[`PDR_POL_BIT] = s_q.pol;
                    s_d.rdata[`PDR_JAB_BIT] = s_q.jab_dis;
                end
                `PDR_A_ERRGAP: begin
                    s_d.rdata[`PDR_ERR_HI:`PDR_ERR_LO] =
                        s_q.err_lat;
                    s_d.rdata[`PDR_IPG_HI:0] = s_q.ipg;
                end
                `PDR_A_PKTLEN: begin
                    s_d.rdata[`PDR_LEN_HI:0] = s_q.len;
                end
                `PDR_A_CDIAG: begin
                    s_d.rdata[`PDR_CDS_BIT] =
                        (s_q.cd == PDR_CD_RUN);
                    s_d.rdata[`PDR_CDD_BIT] =
                        (s_q.cd == PDR_CD_IDLE);
                    s_d.rdata[`PDR_CDF_BIT] = s_q.cd_fail;
                end
                `PDR_A_RSTCTL: begin
                    // self-clearing bits are gone by any read
                    s_d.rdata = 16'h0000;
                end
                `PDR_A_INTST: begin
                    s_d.rdata[`PDR_NINT-1:0] = s_q.int_st;
                end
                `PDR_A_INTMK: begin
                    s_d.rdata[`PDR_NINT-1:0] = s_q.int_mk;
                end
                default: begin
                    s_d.rdata = 16'h0000;
                end
            endcase
        end

        // registered copies so outputs leave flops
        s_d.jab_en = !s_d.jab_dis && SPEED10;
        s_d.irq    = |(s_d.int_st & s_d.int_mk);

        // soft reset replays the pin reset one cycle on
        if (s_q.swrst) begin
            s_d = rst_val();
        end
    end

    // single register for the whole bank
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            s_q <= rst_val();
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from the state flops
    assign RDATA      = s_q.rdata;
    assign SQUELCH    = s_q.squelch;
    assign NLP_OFF    = s_q.nlp_dis;
    assign POL_MIRROR = s_q.pol;
    assign JABBER_EN  = s_q.jab_en;
    assign IPG_LEN    = s_q.ipg;
    assign PKT_LEN    = s_q.len;
    assign CD_START   = (s_q.cd == PDR_CD_RUN);
    assign SOFT_RST   = s_q.swrst;
    assign DIG_RST    = s_q.digrst;
    assign IRQ        = s_q.irq;

    // checks on the bank's own behaviour
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!NRST);

    sequence s_wr_tenb;
        WR && ADDR == `PDR_A_TENB && !s_q.swrst;
    endsequence

    sequence s_cd_go;
        WR && ADDR == `PDR_A_CDIAG && WDATA[`PDR_CDS_BIT]
            && !CD_START && !s_q.swrst;
    endsequence

    sequence s_cd_end;
        CD_START && CD_DONE && !s_q.swrst;
    endsequence

    property p_squelch;
        s_wr_tenb |=> SQUELCH == $past(WDATA[12:9]);
    endproperty
    a_squelch: assert property (p_squelch)
        else $error("squelch field not taken");

    property p_nlp;
        s_wr_tenb |=> NLP_OFF == $past(WDATA[7]);
    endproperty
    a_nlp: assert property (p_nlp)
        else $error("link pulse control not taken");

    property p_pol_set;
        POL_DET && !s_q.swrst |=> POL_MIRROR;
    endproperty
    a_pol_set: assert property (p_pol_set)
        else $error("polarity flag not set");

    property p_pol_clr;
        RD && ADDR == `PDR_A_TENB && POL_MIRROR && !POL_DET
            && !s_q.swrst |=> !POL_MIRROR && RDATA[4];
    endproperty
    a_pol_clr: assert property (p_pol_clr)
        else $error("polarity read clear wrong");

    property p_jab;
        JABBER_EN |-> $past(SPEED10);
    endproperty
    a_jab: assert property (p_jab)
        else $error("jabber enabled outside 10 Mb/s");

    property p_latch;
        WR && ADDR == `PDR_A_ERRGAP && WDATA[15] && !s_q.swrst
            |=> s_q.err_lat == $past(cif.count)
            && cif.count == 8'h00;
    endproperty
    a_latch: assert property (p_latch)
        else $error("error count latch or clear failed");

    property p_sat;
        cif.count == 8'hFF && !ERR_MODE && !cif.clr
            |=> cif.count == 8'hFF;
    endproperty
    a_sat: assert property (p_sat)
        else $error("error counter wrapped in mode zero");

    property p_cd_go;
        s_cd_go |=> CD_START ##1 (CD_START || $past(CD_DONE)
            || $past(WR));
    endproperty
    a_cd_go: assert property (p_cd_go)
        else $error("cable start not taken");

    property p_cd_end;
        s_cd_end |=> !CD_START && s_q.cd_fail == $past(CD_FAIL);
    endproperty
    a_cd_end: assert property (p_cd_end)
        else $error("start not cleared at done");

    property p_swrst;
        SOFT_RST |=> !SOFT_RST && IPG_LEN == 8'h7D
            && PKT_LEN == 11'h5EE && !CD_START;
    endproperty
    a_swrst: assert property (p_swrst)
        else $error("soft reset did not restore defaults");

    property p_digrst;
        DIG_RST && !SOFT_RST && !WR |=> !DIG_RST && $stable(IPG_LEN)
            && $stable(PKT_LEN) && cif.count == 8'h00;
    endproperty
    a_digrst: assert property (p_digrst)
        else $error("digital restart disturbed registers");

    property p_rsvd;
        RD && ADDR == `PDR_A_CDIAG |=> RDATA[14:2] == 13'h0000;
    endproperty
    a_rsvd: assert property (p_rsvd)
        else $error("reserved cable bits not zero");

    property p_ipg;
        WR && ADDR == `PDR_A_ERRGAP && !s_q.swrst
            |=> IPG_LEN == $past(WDATA[7:0]);
    endproperty
    a_ipg: assert property (p_ipg)
        else $error("packet gap not taken");

    property p_len;
        WR && ADDR == `PDR_A_PKTLEN && !s_q.swrst
            |=> PKT_LEN == $past(WDATA[10:0]);
    endproperty
    a_len: assert property (p_len)
        else $error("packet length not taken");

    // done reads as the inverse of a running measurement
    property p_done;
        RD && ADDR == `PDR_A_CDIAG && !s_q.swrst
            |=> RDATA[1] == !$past(CD_START)
            && RDATA[15] == $past(CD_START);
    endproperty
    a_done: assert property (p_done)
        else $error("cable done flag wrong");

    // an unmasked event must raise the level one cycle on
    property p_irq;
        (ev & s_q.int_mk) != 4'h0 && !s_q.swrst
            && !(WR && ADDR == `PDR_A_INTMK) |=> IRQ;
    endproperty
    a_irq: assert property (p_irq)
        else $error("unmasked event did not raise interrupt");

endmodule

/* test/tb_top.sv */
// self-checking bench for the phy diagnostic register bank
`timescale 1ns/1ns
`include "pdr_params.svh"
module tb_top;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic [5:0]  addr = 6'h00;
    logic [15:0] wdata = 16'h0000;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        pol_det = 1'b0;
    logic        prbs_err = 1'b0;
    logic        err_mode = 1'b0;
    logic        speed10 = 1'b1;
    logic        cd_done = 1'b0;
    logic        cd_fail = 1'b0;
    logic [15:0] rdata;
    logic [3:0]  squelch;
    logic        nlp_off;
    logic        pol_mirror;
    logic        jabber_en;
    logic [7:0]  ipg_len;
    logic [10:0] pkt_len;
    logic        cd_start;
    logic        soft_rst;
    logic        dig_rst;
    logic        irq;
    int          miscompares = 0;
    int          total_checks = 0;

    // 20 MHz clock
    always #25 clk = ~clk;

    pdr_regs i_dut (
        .CLK        (clk),
        .NRST       (nrst),
        .ADDR       (addr),
        .WDATA      (wdata),
        .WR         (wr),
        .RD         (rd),
        .RDATA      (rdata),
        .POL_DET    (pol_det),
        .PRBS_ERR   (prbs_err),
        .ERR_MODE   (err_mode),
        .SPEED10    (speed10),
        .CD_DONE    (cd_done),
        .CD_FAIL    (cd_fail),
        .SQUELCH    (squelch),
        .NLP_OFF    (nlp_off),
        .POL_MIRROR (pol_mirror),
        .JABBER_EN  (jabber_en),
        .IPG_LEN    (ipg_len),
        .PKT_LEN    (pkt_len),
        .CD_START   (cd_start),
        .SOFT_RST   (soft_rst),
        .DIG_RST    (dig_rst),
        .IRQ        (irq)
    );

    // one comparison, four-state exact
    task automatic chk(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // bus cycles end at the falling edge so results have settled
    task automatic wr_reg(input logic [5:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(negedge clk);
    endtask

    // read data only stands in the cycle after the strobe
    task automatic rd_chk(input logic [5:0] a, input logic [15:0] e,
                          input string what);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk(what, rdata, e);
    endtask

    // prbs error held high for n sampled edges
    task automatic burst(input int n);
        @(posedge clk);
        prbs_err <= 1'b1;
        repeat (n) @(posedge clk);
        prbs_err <= 1'b0;
        @(negedge clk);
    endtask

    task automatic done_pulse(input logic f);
        @(posedge clk);
        cd_done <= 1'b1;
        cd_fail <= f;
        @(posedge clk);
        cd_done <= 1'b0;
        @(negedge clk);
    endtask

    task automatic t_reset();
        chk("ipg_len", ipg_len, 16'h007D);
        chk("pkt_len", pkt_len, 16'h05EE);
        chk("cd_start", cd_start, 16'h0000);
        rd_chk(`PDR_A_TENB, 16'h0000, "tenb");
        rd_chk(`PDR_A_ERRGAP, 16'h007D, "errgap");
        rd_chk(`PDR_A_PKTLEN, 16'h05EE, "pktlen");
        rd_chk(`PDR_A_CDIAG, 16'h0002, "cdiag");
        rd_chk(`PDR_A_RSTCTL, 16'h0000, "rstctl");
        rd_chk(6'h05, 16'h0000, "unmapped");
        $display("test reset done");
    endtask

    task automatic t_tenbase();
        for (int i = 0; i < 16; i++) begin
            wr_reg(`PDR_A_TENB, {3'h0, 4'(i), 9'h000});
            chk("squelch", 16'(squelch), 16'(i));
        end
        wr_reg(`PDR_A_TENB, 16'hFFFF);
        @(negedge clk);
        chk("nlp_off", nlp_off, 16'h0001);
        chk("jabber off", jabber_en, 16'h0000);
        rd_chk(`PDR_A_TENB, 16'h1E81, "tenb bits");
        @(posedge clk);
        speed10 <= 1'b0;
        wr_reg(`PDR_A_TENB, 16'h0000);
        @(negedge clk);
        chk("jabber fast", jabber_en, 16'h0000);
        chk("nlp_on", nlp_off, 16'h0000);
        @(posedge clk);
        speed10 <= 1'b1;
        repeat (2) @(negedge clk);
        chk("jabber on", jabber_en, 16'h0001);
        $display("test tenbase done");
    endtask

    task automatic t_polarity();
        @(posedge clk);
        pol_det <= 1'b1;
        @(posedge clk);
        pol_det <= 1'b0;
        @(negedge clk);
        chk("pol_mirror", pol_mirror, 16'h0001);
        chk("irq masked", irq, 16'h0000);
        rd_chk(`PDR_A_INTST, 16'h0001, "intst pol");
        chk("pol kept", pol_mirror, 16'h0001);
        rd_chk(`PDR_A_TENB, 16'h0010, "pol read");
        chk("pol cleared", pol_mirror, 16'h0000);
        rd_chk(`PDR_A_TENB, 16'h0000, "pol reread");
        wr_reg(`PDR_A_INTMK, 16'h000F);
        @(negedge clk);
        chk("irq up", irq, 16'h0001);
        wr_reg(`PDR_A_INTST, 16'h0001);
        @(negedge clk);
        chk("irq down", irq, 16'h0000);
        $display("test polarity done");
    endtask

    task automatic t_errcount();
        burst(3);
        wr_reg(`PDR_A_ERRGAP, 16'h8000);
        chk("ipg zero", ipg_len, 16'h0000);
        burst(2);
        rd_chk(`PDR_A_ERRGAP, 16'h0300, "latched 3");
        wr_reg(`PDR_A_ERRGAP, 16'h8000);
        rd_chk(`PDR_A_ERRGAP, 16'h0200, "cleared");
        burst(260);
        wr_reg(`PDR_A_ERRGAP, 16'h8000);
        rd_chk(`PDR_A_ERRGAP, 16'hFF00, "saturate");
        rd_chk(`PDR_A_INTST, 16'h0008, "intst sat");
        wr_reg(`PDR_A_INTST, 16'h0008);
        @(posedge clk);
        err_mode <= 1'b1;
        burst(257);
        wr_reg(`PDR_A_ERRGAP, 16'h8000);
        rd_chk(`PDR_A_ERRGAP, 16'h0100, "wrap");
        @(posedge clk);
        err_mode <= 1'b0;
        wr_reg(`PDR_A_ERRGAP, 16'h0042);
        chk("ipg", ipg_len, 16'h0042);
        rd_chk(`PDR_A_ERRGAP, 16'h0142, "errgap");
        wr_reg(`PDR_A_PKTLEN, 16'hFFFF);
        chk("pkt_len", pkt_len, 16'h07FF);
        rd_chk(`PDR_A_PKTLEN, 16'h07FF, "pktlen");
        $display("test errcount done");
    endtask

    task automatic t_cable();
        wr_reg(`PDR_A_CDIAG, 16'h8000);
        chk("cd run", cd_start, 16'h0001);
        rd_chk(`PDR_A_CDIAG, 16'h8000, "cd busy");
        done_pulse(1'b1);
        chk("cd stop", cd_start, 16'h0000);
        rd_chk(`PDR_A_CDIAG, 16'h0003, "cd fail");
        chk("irq cd", irq, 16'h0001);
        rd_chk(`PDR_A_INTST, 16'h0006, "intst cd");
        wr_reg(`PDR_A_INTST, 16'h000F);
        wr_reg(`PDR_A_CDIAG, 16'h8000);
        rd_chk(`PDR_A_CDIAG, 16'h8000, "fail cleared");
        wr_reg(`PDR_A_CDIAG, 16'h0000);
        chk("cd abort", cd_start, 16'h0000);
        done_pulse(1'b0);
        rd_chk(`PDR_A_INTST, 16'h0000, "idle done");
        chk("irq idle", irq, 16'h0000);
        $display("test cable done");
    endtask

    task automatic t_resets();
        burst(4);
        wr_reg(`PDR_A_RSTCTL, 16'h4000);
        chk("dig_rst", dig_rst, 16'h0001);
        @(negedge clk);
        chk("dig_rst end", dig_rst, 16'h0000);
        chk("ipg kept", ipg_len, 16'h0042);
        rd_chk(`PDR_A_RSTCTL, 16'h0000, "rstctl sc");
        wr_reg(`PDR_A_ERRGAP, 16'h8042);
        rd_chk(`PDR_A_ERRGAP, 16'h0042, "count clr");
        wr_reg(`PDR_A_TENB, 16'h1E80);
        wr_reg(`PDR_A_RSTCTL, 16'h8000);
        chk("soft_rst", soft_rst, 16'h0001);
        @(negedge clk);
        chk("soft_rst end", soft_rst, 16'h0000);
        chk("ipg rst", ipg_len, 16'h007D);
        chk("len rst", pkt_len, 16'h05EE);
        chk("sq rst", squelch, 16'h0000);
        rd_chk(`PDR_A_INTMK, 16'h0000, "mask rst");
        rd_chk(`PDR_A_CDIAG, 16'h0002, "cd rst");
        $display("test resets done");
    endtask

    // verdict and end of run
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        @(negedge clk);
        t_reset();
        t_tenbase();
        t_polarity();
        t_errcount();
        t_cable();
        t_resets();
        close_out();
    end

    // watchdog, about fifteen times the expected run of about 670 cycles
    initial begin
        #500000;
        miscompares++;
        close_out();
    end
endmodule
